// ==== rtl/aps_top.sv ====
// audio serial port half-phase framing and status monitor with wishbone registers
//
// Added by the designer: the Wishbone register port and the address map.
`timescale 1ns/1ps
module aps_top (
  input wire logic mclk, // system clock, 100 MHz
  input wire logic rst, // async reset, active high
  input wire logic wb_cyc_i, // wishbone cycle
  input wire logic wb_stb_i, // wishbone strobe
  input wire logic wb_we_i, // wishbone write enable
  input wire logic [aps_pkg::ADR_W-1:0] wb_adr_i, // wishbone byte address
  input wire logic [3:0] wb_sel_i, // wishbone byte lanes
  input wire logic [31:0] wb_dat_i, // wishbone write data
  output logic [31:0] wb_dat_o, // wishbone read data
  output logic wb_ack_o, // wishbone acknowledge
  input wire logic sclk_pin, // serial bit clock from host
  input wire logic fsync_pin, // frame sync from host
  input wire logic rx_overload_evt, // pulse: too many input buffer requests
  input wire logic tx_fetch_fail_evt, // pulse: tx sequencer missed output data
  input wire logic tx_fifo_overflow, // level: output fifo in overflow
  output logic irq, // interrupt, active high
  output logic frame_start, // pulse: frame begins
  output logic [aps_pkg::CNT_W-1:0] bit_location, // channel bit location index
  output logic [1:0] tx_ch_active, // tx channel in its active phase
  output logic [1:0] rx_ch_active // rx channel in its active phase
);

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef struct packed {
    logic wb_ack;
    logic [31:0] rdata;
    logic [aps_pkg::CTRL_W-1:0] ctrl;
    aps_pkg::aps_sync_cfg_t rx_cfg;
    aps_pkg::aps_sync_cfg_t tx_cfg;
    logic [aps_pkg::ST_W-1:0] status;
    logic [aps_pkg::ST_W-1:0] mask;
    logic irq;
    logic sclk_d;
    logic fs_lvl;
    logic in_frame;
    logic frame_start;
    logic [aps_pkg::CNT_W-1:0] loc;
    logic [1:0] tx_act;
    logic [1:0] rx_act;
    logic rx_early_arm;
    logic tx_miss_arm;
    logic tx_seq_arm;
    logic ovf_d;
  } aps_top_state_t;

  aps_top_state_t s_reg;
  aps_top_state_t s_next;

  logic [1:0] pin_sync;
  logic sclk_s;
  logic fs_s;
  logic bit_tick;
  aps_pkg::aps_mon_evt_t rx_evt;
  aps_pkg::aps_mon_evt_t tx_evt;

  // ------------------------------------------------------------
  // pin crossing and bit clock edge
  // ------------------------------------------------------------
  aps_sync2 #(.W(2)) u_pins (
    .mclk(mclk),
    .rst(rst),
    .d({sclk_pin, fsync_pin}),
    .q(pin_sync)
  );

  assign sclk_s = pin_sync[1];
  assign fs_s = pin_sync[0];
  // sclk must stay well below mclk/2 for edges to be seen
  assign bit_tick = sclk_s & ~s_reg.sclk_d;

  // ------------------------------------------------------------
  // sync monitors, one per direction
  // ------------------------------------------------------------
  aps_sync_mon u_rx_mon (
    .mclk(mclk),
    .rst(rst),
    .bit_tick(bit_tick),
    .sync_lvl(fs_s),
    .cfg(s_reg.rx_cfg),
    .evt(rx_evt)
  );

  aps_sync_mon u_tx_mon (
    .mclk(mclk),
    .rst(rst),
    .bit_tick(bit_tick),
    .sync_lvl(fs_s),
    .cfg(s_reg.tx_cfg),
    .evt(tx_evt)
  );

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic [31:0] lane_mask(input logic [3:0] sel);
    lane_mask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] sel);
    merge = (old & ~lane_mask(sel)) | (wd & lane_mask(sel));
  endfunction

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  logic access;
  logic wr;
  logic [31:0] wd;
  logic [31:0] per_word;
  logic [aps_pkg::ST_W-1:0] st_set;
  logic [aps_pkg::ST_W-1:0] st_clr;
  logic half;
  logic ap_on;
  logic rise;
  logic fall;
  logic start_edge;
  logic phase_edge;
  logic [1:0] tx_ap;
  logic [1:0] rx_ap;

  always_comb begin
    s_next = s_reg;
    s_next.wb_ack = 1'b0;
    s_next.frame_start = 1'b0;
    access = wb_cyc_i & wb_stb_i & ~s_reg.wb_ack;
    // the write lands on the edge where the master samples ack
    wr = wb_cyc_i & wb_stb_i & wb_we_i & s_reg.wb_ack;
    wd = wb_dat_i;
    per_word = 32'h0000_0000;
    st_set = '0;
    st_clr = '0;

    // ---------------- bus slave ----------------
    if (access) begin
      s_next.wb_ack = 1'b1;
      case (wb_adr_i)
        aps_pkg::OFS_CTRL: s_next.rdata = {24'h00_0000, s_reg.ctrl};
        aps_pkg::OFS_RX_PERIOD: s_next.rdata = {7'h00, s_reg.rx_cfg.high, 7'h00,
                                                s_reg.rx_cfg.period};
        aps_pkg::OFS_TX_PERIOD: s_next.rdata = {7'h00, s_reg.tx_cfg.high, 7'h00,
                                                s_reg.tx_cfg.period};
        aps_pkg::OFS_STATUS: s_next.rdata = {23'h00_0000, s_reg.status};
        aps_pkg::OFS_MASK: s_next.rdata = {23'h00_0000, s_reg.mask};
        aps_pkg::OFS_FRAME: s_next.rdata = {16'h0000, s_reg.rx_act, s_reg.tx_act,
                                            s_reg.fs_lvl, s_reg.in_frame, 1'b0,
                                            s_reg.loc};
        default: s_next.rdata = 32'h0000_0000;
      endcase
    end
    if (wr) begin
      case (wb_adr_i)
        aps_pkg::OFS_CTRL: begin
          per_word = merge({24'h00_0000, s_reg.ctrl}, wd, wb_sel_i);
          s_next.ctrl = per_word[aps_pkg::CTRL_W-1:0];
        end
        aps_pkg::OFS_RX_PERIOD: begin
          per_word = merge({7'h00, s_reg.rx_cfg.high, 7'h00, s_reg.rx_cfg.period},
                           wd, wb_sel_i);
          s_next.rx_cfg.period = per_word[aps_pkg::CNT_W-1:0];
          s_next.rx_cfg.high = per_word[aps_pkg::PER_HIGH_POS +: aps_pkg::CNT_W];
        end
        aps_pkg::OFS_TX_PERIOD: begin
          per_word = merge({7'h00, s_reg.tx_cfg.high, 7'h00, s_reg.tx_cfg.period},
                           wd, wb_sel_i);
          s_next.tx_cfg.period = per_word[aps_pkg::CNT_W-1:0];
          s_next.tx_cfg.high = per_word[aps_pkg::PER_HIGH_POS +: aps_pkg::CNT_W];
        end
        aps_pkg::OFS_STATUS: begin
          per_word = wd & lane_mask(wb_sel_i);
          st_clr = per_word[aps_pkg::ST_W-1:0];
        end
        aps_pkg::OFS_MASK: begin
          per_word = merge({23'h00_0000, s_reg.mask}, wd, wb_sel_i);
          s_next.mask = per_word[aps_pkg::ST_W-1:0];
        end
        default: per_word = 32'h0000_0000;
      endcase
    end

    // ---------------- framing ----------------
    half = s_reg.ctrl[aps_pkg::CTRL_HALF_PHASE];
    // double rate reuses the phase split, so per-channel phases give way
    ap_on = half & ~s_reg.ctrl[aps_pkg::CTRL_RX_IF0_DR]
                 & ~s_reg.ctrl[aps_pkg::CTRL_RX_IF1_DR];
    tx_ap = ap_on ? s_reg.ctrl[aps_pkg::CTRL_TX_AP +: 2] : 2'b10;
    rx_ap = ap_on ? s_reg.ctrl[aps_pkg::CTRL_RX_AP +: 2] : 2'b10;
    rise = bit_tick & fs_s & ~s_reg.fs_lvl;
    fall = bit_tick & ~fs_s & s_reg.fs_lvl;
    // both modes take the chosen edge against the last sampled level fs_lvl; that edge alone opens a frame
    start_edge = (half & s_reg.ctrl[aps_pkg::CTRL_START_PHASE]) ? rise : fall;
    phase_edge = half ? (rise | fall) : start_edge;
    if (bit_tick) begin
      s_next.fs_lvl = fs_s;
      if (start_edge) begin
        s_next.frame_start = 1'b1;
        s_next.in_frame = 1'b1;
      end
      if (phase_edge) begin
        s_next.loc = '0;
      end else if (s_reg.in_frame && s_reg.loc != '1) begin
        s_next.loc = s_reg.loc + 9'h001;
      end
      for (int i = 0; i < 2; i++) begin
        s_next.tx_act[i] = (s_next.in_frame) & (fs_s == tx_ap[i]);
        s_next.rx_act[i] = (s_next.in_frame) & (fs_s == rx_ap[i]);
      end
    end
    s_next.sclk_d = sclk_s;

    // ---------------- status events ----------------
    st_set[aps_pkg::ST_RX_OVLD] = rx_overload_evt;
    st_set[aps_pkg::ST_RX_EARLY] = rx_evt.early & s_reg.rx_early_arm;
    st_set[aps_pkg::ST_RX_LATE] = rx_evt.late;
    st_set[aps_pkg::ST_RX_ERR] = st_set[aps_pkg::ST_RX_EARLY] | rx_evt.late;
    st_set[aps_pkg::ST_RX_MISS] = rx_evt.missing;
    st_set[aps_pkg::ST_TX_EARLY] = tx_evt.early;
    st_set[aps_pkg::ST_TX_LATE] = tx_evt.late;
    st_set[aps_pkg::ST_TX_MISS] = tx_evt.missing & s_reg.tx_miss_arm;
    st_set[aps_pkg::ST_TX_SEQ] = tx_fetch_fail_evt & s_reg.tx_seq_arm;

    // arms mute repeats of one error until the link looks healthy again
    if (rx_evt.valid) begin
      s_next.rx_early_arm = 1'b1;
    end else if (st_set[aps_pkg::ST_RX_EARLY]) begin
      s_next.rx_early_arm = 1'b0;
    end
    if (tx_evt.valid) begin
      s_next.tx_miss_arm = 1'b1;
    end else if (st_set[aps_pkg::ST_TX_MISS]) begin
      s_next.tx_miss_arm = 1'b0;
    end
    // only the overflow exit re-arms, a later good fetch alone does not
    s_next.ovf_d = tx_fifo_overflow;
    if (s_reg.ovf_d & ~tx_fifo_overflow) begin
      s_next.tx_seq_arm = 1'b1;
    end else if (st_set[aps_pkg::ST_TX_SEQ]) begin
      s_next.tx_seq_arm = 1'b0;
    end

    // a set arriving with its clear wins
    s_next.status = (s_reg.status & ~st_clr) | st_set;
    s_next.irq = |(s_next.status & s_reg.mask);
  end

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      s_reg <= '0;
      s_reg.ctrl <= aps_pkg::CTRL_RST;
      s_reg.rx_cfg.period <= aps_pkg::PERIOD_RST;
      s_reg.rx_cfg.high <= aps_pkg::HIGH_RST;
      s_reg.tx_cfg.period <= aps_pkg::PERIOD_RST;
      s_reg.tx_cfg.high <= aps_pkg::HIGH_RST;
      s_reg.status <= aps_pkg::ST_RST;
      s_reg.mask <= aps_pkg::MASK_RST;
      s_reg.rx_early_arm <= 1'b1;
      s_reg.tx_miss_arm <= 1'b1;
      s_reg.tx_seq_arm <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign wb_ack_o = s_reg.wb_ack;
  assign wb_dat_o = s_reg.rdata;
  assign irq = s_reg.irq;
  assign frame_start = s_reg.frame_start;
  assign bit_location = s_reg.loc;
  assign tx_ch_active = s_reg.tx_act;
  assign rx_ch_active = s_reg.rx_act;

endmodule

// ==== rtl/aps_pkg.sv ====
// shared constants and carrier types of the audio serial port phase/status block
package aps_pkg;

  // ------------------------------------------------------------
  // widths
  // ------------------------------------------------------------
  localparam int CNT_W = 9;
  localparam int ADR_W = 8;

  // ------------------------------------------------------------
  // register offsets (byte addresses)
  // ------------------------------------------------------------
  localparam logic [ADR_W-1:0] OFS_CTRL = 8'h00;
  localparam logic [ADR_W-1:0] OFS_RX_PERIOD = 8'h04;
  localparam logic [ADR_W-1:0] OFS_TX_PERIOD = 8'h08;
  localparam logic [ADR_W-1:0] OFS_STATUS = 8'h0c;
  localparam logic [ADR_W-1:0] OFS_MASK = 8'h10;
  localparam logic [ADR_W-1:0] OFS_FRAME = 8'h14;

  // ------------------------------------------------------------
  // control fields
  // ------------------------------------------------------------
  localparam int CTRL_HALF_PHASE = 0;
  localparam int CTRL_START_PHASE = 1;
  localparam int CTRL_RX_IF0_DR = 2;
  localparam int CTRL_RX_IF1_DR = 3;
  localparam int CTRL_TX_AP = 4;
  localparam int CTRL_RX_AP = 6;
  localparam int CTRL_W = 8;
  localparam logic [CTRL_W-1:0] CTRL_RST = 8'h00;

  // period register: count in [8:0], high count in [24:16]
  localparam int PER_HIGH_POS = 16;
  localparam logic [CNT_W-1:0] PERIOD_RST = 9'h040;
  localparam logic [CNT_W-1:0] HIGH_RST = 9'h020;

  // ------------------------------------------------------------
  // status bit positions, mask uses the same layout
  // ------------------------------------------------------------
  localparam int ST_RX_OVLD = 0;
  localparam int ST_RX_ERR = 1;
  localparam int ST_RX_EARLY = 2;
  localparam int ST_RX_LATE = 3;
  localparam int ST_RX_MISS = 4;
  localparam int ST_TX_EARLY = 5;
  localparam int ST_TX_LATE = 6;
  localparam int ST_TX_MISS = 7;
  localparam int ST_TX_SEQ = 8;
  localparam int ST_W = 9;
  localparam logic [ST_W-1:0] ST_RST = 9'h000;
  localparam logic [ST_W-1:0] MASK_RST = 9'h000;

  // ------------------------------------------------------------
  // carriers
  // ------------------------------------------------------------
  typedef struct packed {
    logic [CNT_W-1:0] period;
    logic [CNT_W-1:0] high;
  } aps_sync_cfg_t;

  typedef struct packed {
    logic early;
    logic late;
    logic missing;
    logic valid;
  } aps_mon_evt_t;

  typedef struct packed {
    logic lvl;
    logic locked;
    logic [CNT_W-1:0] phase_cnt;
    logic [CNT_W+1:0] idle_cnt;
    aps_mon_evt_t evt;
  } aps_mon_state_t;

endpackage

// ==== rtl/aps_sync2.sv ====
// two-flop synchroniser for pins entering the mclk domain
`timescale 1ns/1ps
module aps_sync2 #(
  parameter int W = 2
) (
  input wire logic mclk, // system clock
  input wire logic rst, // async reset, active high
  input wire logic [W-1:0] d, // asynchronous inputs
  output logic [W-1:0] q // synchronised outputs
);

  logic [W-1:0] meta_reg;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      meta_reg <= '0;
      q <= '0;
    end else begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end

endmodule

// ==== rtl/aps_sync_mon.sv ====
// frame-sync phase length monitor for one direction
`timescale 1ns/1ps
module aps_sync_mon (
  input wire logic mclk, // system clock
  input wire logic rst, // async reset, active high
  input wire logic bit_tick, // one-cycle pulse per bit clock rising edge
  input wire logic sync_lvl, // synchronised frame sync level
  input wire aps_pkg::aps_sync_cfg_t cfg, // programmed period and high counts
  output aps_pkg::aps_mon_evt_t evt // one-cycle event pulses
);

  aps_pkg::aps_mon_state_t s_reg;
  aps_pkg::aps_mon_state_t s_next;

  logic [aps_pkg::CNT_W-1:0] expect_cnt;
  logic [aps_pkg::CNT_W+1:0] miss_lim;

  always_comb begin
    s_next = s_reg;
    s_next.evt = '0;
    expect_cnt = s_reg.lvl ? cfg.high : cfg.period - cfg.high;
    // idle count crossing twice the period fires once, then saturates
    miss_lim = {1'b0, cfg.period, 1'b0} + 11'h001;
    if (bit_tick) begin
      if (sync_lvl != s_reg.lvl) begin
        s_next.lvl = sync_lvl;
        s_next.locked = 1'b1;
        s_next.phase_cnt = 9'h001;
        s_next.idle_cnt = '0;
        // first edge after reset has no measured phase behind it
        if (s_reg.locked) begin
          s_next.evt.early = s_reg.phase_cnt < expect_cnt;
          s_next.evt.late = s_reg.phase_cnt > expect_cnt;
          s_next.evt.valid = s_reg.phase_cnt == expect_cnt;
        end
      end else begin
        if (s_reg.phase_cnt != '1) begin
          s_next.phase_cnt = s_reg.phase_cnt + 9'h001;
        end
        if (s_reg.idle_cnt != '1) begin
          s_next.idle_cnt = s_reg.idle_cnt + 11'h001;
        end
        s_next.evt.missing = (s_reg.idle_cnt + 11'h001) == miss_lim;
      end
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign evt = s_reg.evt;

endmodule

// ==== test/aps_monitor.sv ====
// assertion checker watching the ports of the phase/status block
`timescale 1ns/1ps
module aps_monitor (
  input wire logic mclk, // clock
  input wire logic rst, // reset
  input wire logic wb_cyc_i, // cycle
  input wire logic wb_stb_i, // strobe
  input wire logic wb_we_i, // write
  input wire logic [aps_pkg::ADR_W-1:0] wb_adr_i, // address
  input wire logic [3:0] wb_sel_i, // lanes
  input wire logic [31:0] wb_dat_i, // wdata
  input wire logic [31:0] wb_dat_o, // rdata
  input wire logic wb_ack_o, // ack
  input wire logic sclk_pin, // bit clock
  input wire logic fsync_pin, // sync
  input wire logic rx_overload_evt, // event
  input wire logic tx_fetch_fail_evt, // event
  input wire logic tx_fifo_overflow, // level
  input wire logic irq, // interrupt
  input wire logic frame_start, // pulse
  input wire logic [aps_pkg::CNT_W-1:0] bit_location, // location
  input wire logic [1:0] tx_ch_active, // tx phase
  input wire logic [1:0] rx_ch_active // rx phase
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);
  // ------------------------------------------------------------
  // shadows of software state
  // ------------------------------------------------------------
  logic [7:0] ctrl_sh;
  logic [8:0] mask_sh;
  logic [aps_pkg::CNT_W-1:0] loc_q;
  logic lvl_q;
  logic wr_done;
  logic upd;
  logic half;
  logic [1:0] nrm;
  assign wr_done = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && (wb_sel_i == 4'hf);
  // a tick shows as a location change; fsync is stable for many cycles there
  assign upd = (bit_location != loc_q) || frame_start;
  // double rate overrides the per-channel phases
  assign half = ctrl_sh[0] && !ctrl_sh[2] && !ctrl_sh[3];
  assign nrm = {fsync_pin, !fsync_pin};
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ctrl_sh <= 8'h00;
      mask_sh <= 9'h000;
      loc_q <= 9'h000;
      lvl_q <= 1'b0;
    end else begin
      loc_q <= bit_location;
      if (upd) begin
        lvl_q <= fsync_pin;
      end
      if (wr_done && wb_adr_i == aps_pkg::OFS_CTRL) begin
        ctrl_sh <= wb_dat_i[7:0];
      end
      if (wr_done && wb_adr_i == aps_pkg::OFS_MASK) begin
        mask_sh <= wb_dat_i[8:0];
      end
    end
  end
  // ------------------------------------------------------------
  // properties
  // ------------------------------------------------------------
  a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not acknowledged in one cycle");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held too long");
  a_unmapped_zero: assert property (wb_ack_o && !wb_we_i && wb_adr_i > aps_pkg::OFS_FRAME
    |-> wb_dat_o == 32'h0) else $error("unmapped read not zero");
  a_start_level: assert property (frame_start |-> fsync_pin == (ctrl_sh[0] && ctrl_sh[1]))
    else $error("frame started on wrong sync edge");
  a_start_loc: assert property (frame_start |-> bit_location == 9'h000)
    else $error("frame start with nonzero location");
  a_active_phase: assert property (upd |->
    tx_ch_active == (half ? ~(ctrl_sh[5:4] ^ {2{fsync_pin}}) : nrm) &&
    rx_ch_active == (half ? ~(ctrl_sh[7:6] ^ {2{fsync_pin}}) : nrm))
    else $error("channel active phase wrong");
  a_loc_restart: assert property (upd && half && fsync_pin != lvl_q |-> bit_location == 9'h000)
    else $error("location not restarted at phase start");
  a_loc_count: assert property (upd && half && fsync_pin == lvl_q |-> bit_location == loc_q + 9'h001)
    else $error("location did not advance by one");
  a_irq_masked: assert property ((mask_sh == 9'h000) [*2] |-> !irq)
    else $error("interrupt with all flags masked");
  a_irq_event: assert property (rx_overload_evt && mask_sh[0] |-> ##2 irq)
    else $error("unmasked overload did not interrupt");
  c_half_start: cover property (frame_start && ctrl_sh[0] && fsync_pin);
  c_irq_rise: cover property ($rose(irq));
  c_phase_restart: cover property (upd && half && fsync_pin != lvl_q);
endmodule

// ==== test/aps_host_model.sv ====
// host side model: bit clock and frame sync source
`timescale 1ns/1ps
module aps_host_model (
  output logic sclk, // bit clock
  output logic fsync // frame sync
);
  initial begin
    sclk = 1'b0;
    fsync = 1'b0;
  end
  // clock stands still between calls; sync moves only while sclk is low
  task automatic phase(input int n);
    #3;
    fsync = !fsync;
    repeat (n) begin
      #80 sclk = 1'b1;
      #80 sclk = 1'b0;
    end
  endtask
endmodule

// ==== test/aps_top_tb_top.sv ====
// self-checking bench for the phase/status block
`timescale 1ns/1ps
module aps_top_tb_top;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [aps_pkg::ADR_W-1:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic ovl = 1'b0;
  logic ffail = 1'b0;
  logic fovf = 1'b0;
  wire sclk;
  wire fsync;
  logic [31:0] rdat;
  logic ack;
  logic irq;
  logic fs;
  logic [aps_pkg::CNT_W-1:0] loc;
  logic [1:0] txa;
  logic [1:0] rxa;
  int n_errors = 0;
  int checked = 0;
  int n_fs = 0;
  always #5 mclk = ~mclk;
  always @(posedge mclk) begin
    if (fs === 1'b1) n_fs <= n_fs + 1;
  end
  aps_top i_aps_top (.mclk(mclk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .sclk_pin(sclk), .fsync_pin(fsync), .rx_overload_evt(ovl), .tx_fetch_fail_evt(ffail),
    .tx_fifo_overflow(fovf), .irq(irq), .frame_start(fs), .bit_location(loc),
    .tx_ch_active(txa), .rx_ch_active(rxa));
  aps_host_model i_aps_host_model (.sclk(sclk), .fsync(fsync));
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task automatic tally_and_finish();
    if (n_errors == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int n;
    n = 0;
    @(posedge mclk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge mclk);
      n++;
    end while (ack !== 1'b1 && n < 100);
    if (n >= 100) n_errors++;
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rd_cmp(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    cmp(q, e);
  endtask
  task automatic st_clr(input logic [31:0] e);
    rd_cmp(aps_pkg::OFS_STATUS, e);
    wr(aps_pkg::OFS_STATUS, 32'h1ff);
  endtask
  task automatic irq_cmp(input logic e);
    repeat (3) @(negedge mclk);
    cmp({31'h0, irq}, {31'h0, e});
  endtask
  // zero means no phase
  task automatic run(input int a, input int b, input int c, input int d);
    if (a > 0) i_aps_host_model.phase(a);
    if (b > 0) i_aps_host_model.phase(b);
    if (c > 0) i_aps_host_model.phase(c);
    if (d > 0) i_aps_host_model.phase(d);
  endtask
  task automatic pulse_ovl();
    @(posedge mclk);
    ovl <= 1'b1;
    @(posedge mclk);
    ovl <= 1'b0;
  endtask
  task automatic pulse_fail();
    @(posedge mclk);
    ffail <= 1'b1;
    @(posedge mclk);
    ffail <= 1'b0;
  endtask
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_reset();
    rd_cmp(aps_pkg::OFS_CTRL, 32'h0);
    rd_cmp(aps_pkg::OFS_RX_PERIOD, {7'h0, aps_pkg::HIGH_RST, 7'h0, aps_pkg::PERIOD_RST});
    rd_cmp(aps_pkg::OFS_STATUS, 32'h0);
    rd_cmp(aps_pkg::OFS_MASK, 32'h0);
    wr(8'h40, 32'hffffffff);
    rd_cmp(8'h40, 32'h0);
  endtask
  // expected phases are 4 high, 4 low; the pending phase closes at the next call
  task automatic t_sync();
    wr(aps_pkg::OFS_RX_PERIOD, 32'h00040008);
    wr(aps_pkg::OFS_TX_PERIOD, 32'h00040008);
    run(4, 4, 4, 4);
    rd_cmp(aps_pkg::OFS_STATUS, 32'h0);
    run(2, 2, 0, 0);
    rd_cmp(aps_pkg::OFS_STATUS, 32'h026);
    wr(aps_pkg::OFS_STATUS, 32'h0);
    rd_cmp(aps_pkg::OFS_STATUS, 32'h026);
    wr(aps_pkg::OFS_STATUS, 32'h1ff);
    rd_cmp(aps_pkg::OFS_STATUS, 32'h0);
    run(6, 0, 0, 0);
    st_clr(32'h020);
    run(4, 0, 0, 0);
    st_clr(32'h04a);
    run(2, 4, 0, 0);
    st_clr(32'h026);
  endtask
  task automatic t_missing();
    run(20, 0, 0, 0);
    st_clr(32'h090);
    run(20, 0, 0, 0);
    st_clr(32'h05a);
    run(4, 4, 20, 0);
    st_clr(32'h0da);
    run(4, 0, 0, 0);
    wr(aps_pkg::OFS_STATUS, 32'h1ff);
  endtask
  task automatic t_events();
    pulse_ovl();
    st_clr(32'h001);
    pulse_fail();
    st_clr(32'h100);
    pulse_fail();
    rd_cmp(aps_pkg::OFS_STATUS, 32'h0);
    @(posedge mclk);
    fovf <= 1'b1;
    repeat (3) @(posedge mclk);
    fovf <= 1'b0;
    pulse_fail();
    st_clr(32'h100);
  endtask
  task automatic t_irq();
    // only the path in use is unmasked
    wr(aps_pkg::OFS_MASK, 32'h001);
    pulse_ovl();
    irq_cmp(1'b1);
    wr(aps_pkg::OFS_STATUS, 32'h0);
    irq_cmp(1'b1);
    wr(aps_pkg::OFS_MASK, 32'h0);
    irq_cmp(1'b0);
    wr(aps_pkg::OFS_MASK, 32'h001);
    irq_cmp(1'b1);
    wr(aps_pkg::OFS_STATUS, 32'h001);
    irq_cmp(1'b0);
    wr(aps_pkg::OFS_MASK, 32'h0);
  endtask
  task automatic t_framing();
    int n0;
    for (int k = 0; k < 4; k++) begin
      wr(aps_pkg::OFS_CTRL, {24'h0, ~k[1:0], k[1:0], 2'b00, k[0], 1'b1});
      n0 = n_fs;
      run(4, 4, 4, 4);
      cmp(n_fs - n0, 32'h2);
      cmp({23'h0, loc}, 32'h3);
      cmp({28'h0, rxa, txa}, {28'h0, k[1:0], ~k[1:0]});
    end
    wr(aps_pkg::OFS_CTRL, 32'h05);
    run(4, 4, 0, 0);
    cmp({28'h0, rxa, txa}, 32'h5);
    rd_cmp(aps_pkg::OFS_FRAME, 32'h5403);
    wr(aps_pkg::OFS_CTRL, 32'h0);
    n0 = n_fs;
    run(4, 4, 4, 4);
    cmp(n_fs - n0, 32'h2);
  endtask
  initial begin
    repeat (10) @(posedge mclk);
    rst <= 1'b0;
    t_reset();
    t_sync();
    t_missing();
    t_events();
    t_irq();
    t_framing();
    tally_and_finish();
  end
  initial begin
    #300000;
    n_errors++;
    tally_and_finish();
  end
endmodule
bind aps_top aps_monitor i_aps_monitor (.mclk(mclk), .rst(rst), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
  .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .sclk_pin(sclk_pin),
  .fsync_pin(fsync_pin), .rx_overload_evt(rx_overload_evt),
  .tx_fetch_fail_evt(tx_fetch_fail_evt), .tx_fifo_overflow(tx_fifo_overflow), .irq(irq),
  .frame_start(frame_start), .bit_location(bit_location), .tx_ch_active(tx_ch_active),
  .rx_ch_active(rx_ch_active));
